// [logic/acc_top.sv]
// Control, sequencing and host interface of the converter
`timescale 1ns/10ps
module acc_top
  import acc_pkg::*;
#(
  parameter logic [acc_pkg::CNT_W-1:0] POR_WAIT = acc_pkg::POR_WAIT_CYC,
  parameter logic [acc_pkg::CNT_W-1:0] CAL_LEN = acc_pkg::CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic special_register_select,
  input wire logic upper_byte_select,
  input wire logic channel_pick_bit0,
  input wire logic channel_pick_bit1,
  input wire logic trim_pin_n,
  input wire logic supply_fail,
  input wire logic [acc_pkg::BUS_W-1:0] data_in,
  output logic [acc_pkg::BUS_W-1:0] data_out,
  output logic data_oe_n,
  output logic busy,
  input wire logic comp_in,
  input wire logic trim_overflow,
  output logic [1:0] channel_sel,
  output logic sample_en,
  output logic [acc_pkg::RES_W-1:0] sar_trial,
  output logic trim_run,
  output logic power_down
);
  import acc_pkg::*;

  //--------------------------------------------------------------------
  // Pin synchronisation
  //--------------------------------------------------------------------
  localparam int PIN_W = BUS_W + 9;
  // Idle levels: chip select, strobes and pin 26 high, other selects, channel and fail detect low
  localparam logic [PIN_W-1:0] PIN_IDLE = {9'h1E0, 8'h00};

  logic [PIN_W-1:0] pin_raw; // Gathered pins
  logic [PIN_W-1:0] pin_s; // Synchronised pins
  logic cs_s; // Chip select, active low
  logic rd_s; // Read strobe, active low
  logic wr_s; // Write strobe, active low
  logic rs_s; // Special register select
  logic hbe_s; // Upper byte select
  logic [1:0] chan_s; // Channel address
  logic trim_s; // Pin 26 level
  logic fail_s; // Supply failure detect
  logic [BUS_W-1:0] din_s; // Write data

  assign pin_raw = {chip_select_n, read_n, write_n, trim_pin_n,
                    special_register_select, upper_byte_select,
                    channel_pick_bit1, channel_pick_bit0, supply_fail,
                    data_in};

  acc_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_IDLE)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign cs_s = pin_s[PIN_W-1];
  assign rd_s = pin_s[PIN_W-2];
  assign wr_s = pin_s[PIN_W-3];
  assign trim_s = pin_s[PIN_W-4];
  assign rs_s = pin_s[PIN_W-5];
  assign hbe_s = pin_s[PIN_W-6];
  assign chan_s = pin_s[PIN_W-7:PIN_W-8];
  assign fail_s = pin_s[BUS_W];
  assign din_s = pin_s[BUS_W-1:0];

  //--------------------------------------------------------------------
  // State declarations
  //--------------------------------------------------------------------
  acc_state_e state_reg; // Sequencer state
  logic [CNT_W-1:0] cnt_reg; // Cycles spent in current state
  logic wr_act_reg; // Internal write pulse seen last cycle
  logic trim_prev_reg; // Pin 26 level last cycle
  logic fail_prev_reg; // Supply fail level last cycle
  logic lat_rs_reg; // Selects captured during the write pulse
  logic lat_hbe_reg;
  logic [1:0] lat_chan_reg; // Address captured during the write pulse
  logic [BUS_W-1:0] lat_data_reg; // Data captured during the write pulse
  logic latch_mode_reg; // Output latch mode setting
  logic hold_ctrl_reg; // Pin 26 as sample-to-hold control
  logic sleep_reg; // Power-down setting
  logic fault_reg; // Supply fault flag
  logic ovf_reg; // Calibration overflow flag
  logic [RES_W-1:0] sar_reg; // Successive approximation trial word
  logic [RES_W-1:0] result_reg; // Output data register
  logic [1:0] chan_reg; // Selected channel
  logic busy_reg; // Busy pin, low while working

  //--------------------------------------------------------------------
  // Event decode
  //--------------------------------------------------------------------
  logic wr_act; // Internal write pulse, NOR of strobes
  logic wr_rise; // Write strobe just ended
  logic sfr_wr; // Special register write completed
  logic pin_rise; // Rising edge on pin 26
  logic fail_rise; // Supply failure detected
  logic cal_cmd; // Start calibration
  logic conv_cmd; // Start conversion
  logic in_cal; // Calibration sequence owns the converter
  logic acq_done; // Last sampling cycle
  logic sar_done; // Last decision cycle

  assign wr_act = !cs_s && !wr_s;
  assign wr_rise = wr_act_reg && !wr_act; // R1
  assign sfr_wr = wr_rise && lat_rs_reg && lat_hbe_reg; // R13
  assign pin_rise = trim_s && !trim_prev_reg;
  assign fail_rise = fail_s && !fail_prev_reg;
  assign cal_cmd = (pin_rise && !hold_ctrl_reg) ||
                   (sfr_wr && lat_data_reg[TRIM_ACTIVE_BIT]); // R5 R17
  assign conv_cmd = (wr_rise && !lat_rs_reg && !hold_ctrl_reg) || // R1
                    sfr_wr || // R22
                    (pin_rise && hold_ctrl_reg); // R17
  assign in_cal = (state_reg == ACC_WAIT) || (state_reg == ACC_CAL);
  assign acq_done = cnt_reg == ACQ_CYC - 16'h0001;
  assign sar_done = cnt_reg == SAR_CYC - 16'h0001;

  //--------------------------------------------------------------------
  // Write capture
  //--------------------------------------------------------------------
  // Fields are held from the last active cycle, since on the rising
  // edge itself the host may already have moved them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_act_reg <= 1'b0;
      lat_rs_reg <= 1'b0;
      lat_hbe_reg <= 1'b0;
      lat_chan_reg <= 2'h0;
      lat_data_reg <= 8'h00;
    end else begin
      wr_act_reg <= wr_act;
      if (wr_act) begin
        lat_rs_reg <= rs_s;
        lat_hbe_reg <= hbe_s;
        lat_chan_reg <= chan_s;
        lat_data_reg <= din_s;
      end
    end
  end

  //--------------------------------------------------------------------
  // Edge history for pin 26 and supply detect
  //--------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trim_prev_reg <= 1'b1;
      fail_prev_reg <= 1'b0;
    end else begin
      trim_prev_reg <= trim_s;
      fail_prev_reg <= fail_s;
    end
  end

  //--------------------------------------------------------------------
  // Channel latch
  //--------------------------------------------------------------------
  // Latched on every write edge, also in hold-control mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan_reg <= 2'h0;
    end else if (wr_rise) begin
      chan_reg <= lat_chan_reg; // R23
    end
  end

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  // Reset is treated as power-up: the settling wait runs first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ACC_WAIT;
      cnt_reg <= 16'h0000;
    end else if (fail_rise) begin
      state_reg <= ACC_WAIT; // R19 R4
      cnt_reg <= 16'h0000;
    end else if (cal_cmd && state_reg != ACC_WAIT) begin
      state_reg <= ACC_CAL; // R6
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      case (state_reg)
        ACC_IDLE: begin
          cnt_reg <= 16'h0000;
          if (conv_cmd) begin
            state_reg <= ACC_ACQ; // R1
          end
        end
        ACC_WAIT: begin
          if (cnt_reg == POR_WAIT - 16'h0001) begin
            state_reg <= ACC_CAL; // R4
            cnt_reg <= 16'h0000;
          end
        end
        ACC_CAL: begin
          // Convert commands fall through unseen here
          if (cnt_reg == CAL_LEN - 16'h0001) begin
            state_reg <= ACC_ACQ; // R7
            cnt_reg <= 16'h0000;
          end
        end
        ACC_ACQ: begin
          if (acq_done) begin
            state_reg <= ACC_SAR; // R2
            cnt_reg <= 16'h0000;
          end
        end
        ACC_SAR: begin
          if (sar_done) begin
            state_reg <= ACC_IDLE; // R2
            cnt_reg <= 16'h0000;
          end
        end
        default: begin
          state_reg <= ACC_IDLE;
          cnt_reg <= 16'h0000;
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Busy pin
  //--------------------------------------------------------------------
  // Low from the edge that starts work until the last decision edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (fail_rise || cal_cmd) begin
      busy_reg <= 1'b0; // R3
    end else if (state_reg == ACC_IDLE) begin
      busy_reg <= !conv_cmd; // R3
    end else if (state_reg == ACC_SAR && sar_done) begin
      busy_reg <= 1'b1; // R3 R12
    end
  end

  //--------------------------------------------------------------------
  // Successive approximation and output register
  //--------------------------------------------------------------------
  // Trial bit is kept when the comparator says input is above it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sar_reg <= RESULT_RST;
      result_reg <= RESULT_RST;
    end else if (state_reg == ACC_ACQ && acq_done && !cal_cmd &&
                 !fail_rise) begin
      sar_reg <= SAR_MSB;
    end else if (state_reg == ACC_SAR && !cal_cmd && !fail_rise) begin
      for (int i = 0; i < RES_W; i++) begin
        if (i == RES_W - 1 - int'(cnt_reg[3:0])) begin
          sar_reg[i] <= comp_in;
          if (i > 0) begin
            sar_reg[i-1] <= 1'b1;
          end
          if (!latch_mode_reg) begin
            result_reg[i] <= comp_in; // R11
          end
        end
      end
      if (latch_mode_reg && sar_done) begin
        // Final bit is merged here since sar_reg lags one edge
        result_reg <= {sar_reg[RES_W-1:1], comp_in}; // R14
      end
    end
  end

  //--------------------------------------------------------------------
  // Special register settings
  //--------------------------------------------------------------------
  // A supply fault discards every special register setting written so far
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_mode_reg <= LATCH_MODE_RST;
      hold_ctrl_reg <= HOLD_CTRL_RST;
      sleep_reg <= SLEEP_RST; // R18
    end else if (fail_rise) begin
      latch_mode_reg <= LATCH_MODE_RST; // R19
      hold_ctrl_reg <= HOLD_CTRL_RST;
      sleep_reg <= SLEEP_RST;
    end else if (sfr_wr) begin
      latch_mode_reg <= lat_data_reg[OUTPUT_LATCH_MODE_BIT]; // R13
      hold_ctrl_reg <= lat_data_reg[HOLD_CONTROL_SELECT_BIT]; // R17
      sleep_reg <= lat_data_reg[SLEEP_STATE_BIT];
    end else if (pin_rise && !hold_ctrl_reg) begin
      sleep_reg <= 1'b0; // Pin calibration wakes the converter
    end
  end

  //--------------------------------------------------------------------
  // Fault and overflow flags
  //--------------------------------------------------------------------
  // Setting beats clearing when both land on one edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if (fail_rise) begin
        fault_reg <= 1'b1; // R19
      end else if (sfr_wr && !lat_data_reg[SUPPLY_FAULT_BIT]) begin
        fault_reg <= 1'b0; // R20
      end
      if (state_reg == ACC_CAL && trim_overflow) begin
        ovf_reg <= 1'b1; // R21
      end else if (cal_cmd || (state_reg == ACC_WAIT &&
                   cnt_reg == POR_WAIT - 16'h0001)) begin
        ovf_reg <= 1'b0; // R21
      end
    end
  end

  //--------------------------------------------------------------------
  // Host read path
  //--------------------------------------------------------------------
  // Re-evaluated every cycle so a byte select change during a read
  // switches the driven byte
  logic [BUS_W-1:0] sfr_val; // Special register read image
  logic rd_act; // Internal read pulse

  assign rd_act = !cs_s && !rd_s && wr_s;
  assign sfr_val = {!busy_reg, // R25 R16
                    ovf_reg, fault_reg, 1'b0, sleep_reg, hold_ctrl_reg,
                    in_cal, latch_mode_reg}; // R16

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !rd_act;
      if (rs_s && hbe_s) begin
        data_out <= sfr_val; // R15
      end else if (rs_s) begin
        data_out <= 8'h00; // Reserved select pair reads zero
      end else if (hbe_s) begin
        data_out <= {4'h0, result_reg[RES_W-1:BUS_W]}; // R8 R9 R10
      end else begin
        data_out <= result_reg[BUS_W-1:0]; // R8 R10
      end
    end
  end

  //--------------------------------------------------------------------
  // Analog-side controls
  //--------------------------------------------------------------------
  // Power down only while idle, so a sleeping converter still serves
  // a single conversion and then drops back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sample_en <= 1'b0;
      trim_run <= 1'b0;
      power_down <= 1'b1;
      channel_sel <= 2'h0;
    end else begin
      sample_en <= state_reg == ACC_ACQ; // R2
      trim_run <= in_cal;
      power_down <= sleep_reg && state_reg == ACC_IDLE; // R24
      channel_sel <= chan_reg;
    end
  end

  assign busy = busy_reg;
  assign sar_trial = sar_reg;

endmodule : acc_top

// [common/acc_pkg.sv]
// Shared constants for the self-calibrating converter control block
//----------------------------------------------------------------------
// Function
// R1: Write strobe rising edge starts a conversion
// R2: Five sample cycles, then decisions six to seventeen
// R3: Busy low for the whole conversion
// R4: Power-up or supply fault waits, then calibrates
// R5: Calibration from pin rising edge or D1
// R6: Calibration overrides conversion; converts ignored meanwhile
// R7: Calibration cycles then one automatic conversion
// R8: Low byte eight LSBs, high byte MSBs
// R9: Straight binary, right-justified in sixteen bits
// R10: Byte select steers read data live
// R11: Transparent default; decisions copied as made
// R12: Full result valid when busy rises
// R13: Special register D0 selects latched mode
// R14: Latched mode updates only at completion
// R15: Special register read with both selects high
// R16: Status bits mode, calibrating, overflow, busy
// R17: D2 turns pin into hold-control conversion start
// R18: Sleep bit reads high, default after reset
// R19: Supply fault sets flag, clears settings, recalibrates
// R20: Writing D5 low clears supply fault flag
// R21: Overflow flag set on overflow, cleared at start
// R22: Special register write also starts conversion
// R23: Channel address latched on write rising edge
// R24: Conversion while asleep returns to sleep
// R25: Busy flag bit is inverse of busy pin
//----------------------------------------------------------------------
package acc_pkg;

  // Data widths
  localparam int RES_W = 12;                // Converter resolution
  localparam int BUS_W = 8;                 // Host data bus width
  localparam int CNT_W = 16;                // Sequencer counter width

  // Sequencer timing in clock cycles
  localparam logic [CNT_W-1:0] POR_WAIT_CYC = 16'h9211; // 37393 cycles
  localparam logic [CNT_W-1:0] CAL_CYC = 16'h1200;      // 4608 cycles
  localparam logic [CNT_W-1:0] ACQ_CYC = 16'h0005;      // Sampling phase
  localparam logic [CNT_W-1:0] SAR_CYC = 16'h000C;      // Decision phase

  // Special register bit positions
  localparam int OUTPUT_LATCH_MODE_BIT = 0;
  localparam int TRIM_ACTIVE_BIT = 1;
  localparam int HOLD_CONTROL_SELECT_BIT = 2;
  localparam int SLEEP_STATE_BIT = 3;
  localparam int RESERVED_BIT = 4;
  localparam int SUPPLY_FAULT_BIT = 5;
  localparam int TRIM_OVERFLOW_BIT = 6;
  localparam int CONVERTING_FLAG_BIT = 7;

  // Reset values of the written settings
  localparam logic LATCH_MODE_RST = 1'b0;   // Transparent mode
  localparam logic HOLD_CTRL_RST = 1'b0;    // Pin acts as calibration
  localparam logic SLEEP_RST = 1'b1;        // Powered down
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  localparam logic [RES_W-1:0] SAR_MSB = 12'h800; // First trial weight

  // Sequencer states
  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_WAIT,
    ACC_CAL,
    ACC_ACQ,
    ACC_SAR
  } acc_state_e;

endpackage : acc_pkg

// [logic/acc_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module acc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage

  //--------------------------------------------------------------------
  // Double flop
  //--------------------------------------------------------------------
  // Reset value matches the idle level so no false edges at release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : acc_sync

// [testbench/acc_top_assertions.sv]
// Port-level checker for the converter control block
`timescale 1ns/10ps
module acc_top_assertions
  import acc_pkg::*;
#(
  parameter logic [CNT_W-1:0] POR_WAIT = POR_WAIT_CYC,
  parameter logic [CNT_W-1:0] CAL_LEN = CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic data_oe_n,
  input wire logic busy,
  input wire logic [1:0] channel_sel,
  input wire logic sample_en,
  input wire logic trim_run
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Trim run length counter
  // ----------------------------------------
  logic [16:0] trim_cnt_reg; // Cycles of the current trim run
  // Counted here as a 4608-long repetition would crawl in the tools
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trim_cnt_reg <= '0;
    end else if (trim_run) begin
      trim_cnt_reg <= trim_cnt_reg + 17'h00001;
    end else begin
      trim_cnt_reg <= '0;
    end
  end
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  sequence sample_phase_s;
    sample_en [*5] ##1 !sample_en;
  endsequence
  sequence busy_span_s;
    !busy throughout (1'b1 ##15 1'b1);
  endsequence
  sample_len_a:
    assert property ($rose(sample_en) |-> sample_phase_s)
    else $error("sample phase length wrong");
  conv_len_a:
    assert property ($rose(sample_en) |-> busy_span_s ##1 (busy || trim_run))
    else $error("conversion busy span wrong");
  tail_conv_a:
    assert property ($fell(trim_run) |-> ##[15:19] $rose(busy))
    else $error("no conversion after calibration");
  trim_busy_a:
    assert property (trim_run |-> !busy)
    else $error("busy high during calibration");
  cal_quiet_a:
    assert property (trim_run && $past(trim_run) |-> !sample_en)
    else $error("sampling during calibration");
  cal_len_a:
    assert property ($fell(trim_run) |-> (trim_cnt_reg == CAL_LEN) ||
                     (trim_cnt_reg == POR_WAIT + CAL_LEN))
    else $error("calibration length wrong");
  oe_on_a:
    assert property ((!chip_select_n && !read_n && write_n) [*5]
                     |-> !data_oe_n)
    else $error("bus not driven during read");
  oe_src_a:
    assert property (!data_oe_n |-> !$past(chip_select_n, 3) &&
                     !$past(read_n, 3))
    else $error("bus driven without read");
  chan_hold_a:
    assert property ($changed(channel_sel) |-> !$past(write_n, 3) ||
                     !$past(write_n, 4) || !$past(write_n, 5))
    else $error("channel changed without write");
endmodule : acc_top_assertions

bind acc_top acc_top_assertions #(.POR_WAIT(POR_WAIT), .CAL_LEN(CAL_LEN))
  u_acc_top_assertions (.clk_sys(clk_sys), .rst(rst),
  .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
  .data_oe_n(data_oe_n), .busy(busy), .channel_sel(channel_sel),
  .sample_en(sample_en), .trim_run(trim_run));

// [testbench/acc_analog_model.sv]
// Analog front end model: comparator and trim overflow monitor
`timescale 1ns/10ps
module acc_analog_model (
  input wire logic [11:0] level [4],
  input wire logic [1:0] channel_sel,
  input wire logic [11:0] sar_trial,
  input wire logic trim_run,
  input wire logic ovf_req,
  output logic comp_in,
  output logic trim_overflow
);
  // Keep the trial bit while the held input is at or above the trial
  assign comp_in = (level[channel_sel] >= sar_trial);
  // Overflow can only show while the trim sequence runs
  assign trim_overflow = ovf_req & trim_run;
endmodule : acc_analog_model

// [testbench/tb_autocal_adc_control_interface.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_autocal_adc_control_interface;
  import acc_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, srs = 1'b0, ubs = 1'b0;
  logic trim_n = 1'b1, sf = 1'b0, ovf = 1'b0;
  logic [1:0] ch = 2'h0;
  logic [7:0] din = 8'h00;
  logic [11:0] lvl [4];
  logic [7:0] dout, q;
  logic oe_n, busy, cmp, tovf, smp, trun, pd;
  logic [1:0] csel;
  logic [11:0] trial;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  always #20 clk_sys = ~clk_sys;
  // Short counts keep the power-up sequence to a few dozen cycles
  acc_top #(.POR_WAIT(16'h0028), .CAL_LEN(16'h0014)) u_acc_top (
    .clk_sys(clk_sys), .rst(rst), .chip_select_n(cs_n), .read_n(rd_n),
    .write_n(wr_n), .special_register_select(srs),
    .upper_byte_select(ubs), .channel_pick_bit0(ch[0]),
    .channel_pick_bit1(ch[1]), .trim_pin_n(trim_n), .supply_fail(sf),
    .data_in(din), .data_out(dout), .data_oe_n(oe_n), .busy(busy),
    .comp_in(cmp), .trim_overflow(tovf), .channel_sel(csel),
    .sample_en(smp), .sar_trial(trial), .trim_run(trun), .power_down(pd));
  acc_analog_model u_acc_analog_model (.level(lvl), .channel_sel(csel),
    .sar_trial(trial), .trim_run(trun), .ovf_req(ovf), .comp_in(cmp),
    .trim_overflow(tovf));
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Strobes held four cycles so the pin synchronisers see them
  task automatic wr(input logic s, input logic u, input logic [1:0] a,
                    input logic [7:0] d);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    srs <= s;
    ubs <= u;
    ch <= a;
    din <= d;
    cyc(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    cyc(4);
  endtask : wr
  task automatic rd(input logic s, input logic u, output logic [7:0] d);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    srs <= s;
    ubs <= u;
    cyc(5);
    d = dout;
    chk("bus drive", oe_n, 1'b0);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    cyc(5);
  endtask : rd
  task automatic sr(input logic [7:0] e);
    rd(1'b1, 1'b1, q);
    chk("special register", q, e);
  endtask : sr
  // Bounded wait for the busy pin to return high
  task automatic idle(output int c);
    c = 0;
    while (busy !== 1'b1 && c < 5000) begin
      cyc(1);
      c++;
    end
    if (c >= 5000) chk("busy timeout", 1'b0, 1'b1);
  endtask : idle
  // Both bytes read in one access, byte select flipped while held
  task automatic res(input logic [11:0] e);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    srs <= 1'b0;
    ubs <= 1'b0;
    cyc(5);
    chk("low byte", dout, {8'h00, e[7:0]});
    ubs <= 1'b1;
    cyc(5);
    chk("high byte", dout, {12'h000, e[11:8]});
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    cyc(5);
  endtask : res
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // Whole run takes about a thousand cycles; this cuts a hang
  initial begin
    cyc(20000);
    error_cnt++;
    finish_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    lvl = '{12'hA5C, 12'hFFF, 12'h3C7, 12'h000};
    cyc(4);
    rst <= 1'b0;
    idle(n);
    chk("power-up span", 16'(n >= 74 && n <= 84), 16'h0001);
    res(12'hA5C);
    sr(8'h08);
    $display("test power-up done");
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, 1'b0, 2'(i), 8'h00);
      idle(n);
      res(lvl[i]);
      chk("channel", {14'h0, csel}, 16'(i));
      chk("asleep", pd, 1'b1);
    end
    $display("test channels done");
    wr(1'b1, 1'b1, 2'h1, 8'h01);
    idle(n);
    sr(8'h01);
    chk("awake", pd, 1'b0);
    lvl[1] = 12'h123;
    wr(1'b0, 1'b0, 2'h1, 8'h00);
    rd(1'b0, 1'b0, q);
    chk("held byte", q, 8'hFF);
    idle(n);
    res(12'h123);
    $display("test latched done");
    wr(1'b1, 1'b1, 2'h1, 8'h00);
    idle(n);
    lvl[1] = 12'hE00;
    wr(1'b0, 1'b0, 2'h1, 8'h00);
    cyc(5);
    rd(1'b0, 1'b1, q);
    chk("early high byte", q, 8'h0E);
    idle(n);
    res(12'hE00);
    wr(1'b0, 1'b0, 2'h1, 8'h00);
    sr(8'h80);
    chk("busy pin", busy, 1'b0);
    idle(n);
    $display("test transparent done");
    wr(1'b0, 1'b0, 2'h1, 8'h00);
    cyc(2);
    trim_n <= 1'b0;
    ovf <= 1'b1;
    cyc(3);
    trim_n <= 1'b1;
    cyc(6);
    chk("pin calibration", trun, 1'b1);
    wr(1'b0, 1'b0, 2'h1, 8'h00);
    idle(n);
    ovf <= 1'b0;
    sr(8'h40);
    wr(1'b1, 1'b1, 2'h1, 8'h02);
    cyc(2);
    chk("register calibration", trun, 1'b1);
    idle(n);
    sr(8'h00);
    $display("test calibration done");
    wr(1'b1, 1'b1, 2'h0, 8'h04);
    idle(n);
    sr(8'h04);
    lvl[3] = 12'h5A1;
    wr(1'b0, 1'b0, 2'h3, 8'h00);
    // The channel output settles one edge after the task returns
    cyc(1);
    chk("no conversion", busy, 1'b1);
    chk("hold channel", {14'h0, csel}, 16'h0003);
    trim_n <= 1'b0;
    cyc(3);
    trim_n <= 1'b1;
    cyc(4);
    chk("hold start", busy, 1'b0);
    idle(n);
    res(12'h5A1);
    wr(1'b1, 1'b1, 2'h0, 8'h00);
    idle(n);
    $display("test hold control done");
    wr(1'b1, 1'b1, 2'h0, 8'h01);
    idle(n);
    sf <= 1'b1;
    cyc(3);
    sf <= 1'b0;
    cyc(2);
    sr(8'hAA);
    idle(n);
    sr(8'h28);
    wr(1'b1, 1'b1, 2'h0, 8'h08);
    idle(n);
    sr(8'h08);
    rd(1'b1, 1'b0, q);
    chk("reserved read", q, 8'h00);
    $display("test supply fault done");
    finish_test();
  end
endmodule : tb_autocal_adc_control_interface
